// [verilog/tbcnt_top.v]
// Base counter of a 16-bit timer with buffered top and match values.
//
// Operation
// - Flag bottom whenever the counter value becomes zero.
// - Flag max whenever the counter value becomes all ones.
// - Flag top when the counter equals the working top value.
// - Raise update at bottom or top, chosen by the mode bit.
// - Update copies valid buffers into working registers unless lock_update is set.
// - Setting enable starts counting at the prescaled tick rate.
// - With count-on-event enabled, event pulses are counted instead of ticks.
// - Counter value is readable at any time.
// - Count up or down per direction bit until top or bottom.
// - Ticks come from the clock divided by the prescaler.
// - At top while counting up, the next tick clears the counter.
// - At bottom while counting down, the counter reloads the top value.
// - Software counter writes are immediate and beat count, clear, reload.
// - Direction may change while counting; counting follows the new direction.
// - Top value and each match value have a buffer register.
// - Buffer-valid flags set on buffer write, cleared on transfer.
// - Working match registers are directly writable, bypassing the buffer.
// - A direct top write changes the period at once.
// - Top compare is equality only, so a low top lets the counter wrap.
// - Top buffer moves to the working top only on update.
// - Counter is compared with zero and top at all times.
// - Event outputs appear on the tick after the condition.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "tbcnt_defs.vh"
module tbcnt_top (
    input wire clk, // Peripheral clock.
    input wire arst_n, // Asynchronous reset, active low.
    input wire [4:0] addr, // Register index.
    input wire [15:0] wdata, // Write data.
    input wire wr, // Write strobe.
    input wire rd, // Read strobe.
    output reg [15:0] rdata, // Read data, valid the cycle after rd.
    input wire event_in, // Event pulse from event routing, one cycle.
    output reg ev_top, // Top reached, pulse on following tick.
    output reg ev_bottom, // Bottom reached, pulse on following tick.
    output reg ev_max, // Max reached, pulse on following tick.
    output reg [2:0] ev_match, // Match per channel, pulse on following tick.
    output reg update_strobe, // Update condition, pulse on following tick.
    output wire [15:0] count, // Counter value.
    output wire [47:0] match_values // Working match values, channel 0 lowest.
);
    // ======================================================================
    // Reset release
    // ======================================================================
    reg rst_s1;
    reg rst_n;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ======================================================================
    // Control registers
    // ======================================================================
    reg enable;
    reg [2:0] prescale_select;
    reg dir_down;
    reg lock_update;
    reg update_at_bottom;
    reg count_on_event_input_enable;
    reg [15:0] cnt;
    reg [15:0] top_value_buffer;
    reg top_buffer_valid;
    reg [15:0] match_value_buffer_n [0:2];
    reg [2:0] match_buffer_valid_n;
    wire [15:0] top_value;
    wire [15:0] match_value_n [0:2];

    function is_wr;
        input [4:0] a;
        input [4:0] want;
        begin
            is_wr = wr && (a == want);
        end
    endfunction

    wire wr_cnt = is_wr(addr, `TBCNT_A_CNT);
    wire wr_per = is_wr(addr, `TBCNT_A_PER);
    wire wr_top_value_buffer = is_wr(addr, `TBCNT_A_TOP_VALUE_BUFFER);

    // ======================================================================
    // Prescaler and tick
    // ======================================================================
    reg [9:0] pscnt;
    reg [9:0] ps_mask;
    always @* begin
        // Division by 1,2,4,8,16,64,256,1024.
        case (prescale_select)
            3'h0: ps_mask = 10'h000;
            3'h1: ps_mask = 10'h001;
            3'h2: ps_mask = 10'h003;
            3'h3: ps_mask = 10'h007;
            3'h4: ps_mask = 10'h00f;
            3'h5: ps_mask = 10'h03f;
            3'h6: ps_mask = 10'h0ff;
            default: ps_mask = 10'h3ff;
        endcase
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pscnt <= 10'h000;
        end else if (!enable) begin
            pscnt <= 10'h000;
        end else begin
            pscnt <= pscnt + 10'h001;
        end
    end
    wire clk_tick = ((pscnt & ps_mask) == ps_mask);
    // Events bypass the prescaler entirely.
    wire timer_tick = enable & (count_on_event_input_enable ? event_in : clk_tick);

    // ======================================================================
    // Comparators and update condition
    // ======================================================================
    wire at_bottom = (cnt == `TBCNT_ZERO16);
    wire at_max = (cnt == `TBCNT_MAX16);
    // Equality only: a top below the counter is passed over and the counter wraps.
    wire at_top = (cnt == top_value);
    wire upd_cond = update_at_bottom ? at_bottom : at_top;
    wire do_upd = timer_tick & upd_cond & ~lock_update;

    // ======================================================================
    // Counter
    // ======================================================================
    reg [15:0] next_cnt;
    always @* begin
        next_cnt = cnt;
        if (wr_cnt) begin
            next_cnt = wdata;
        end else if (timer_tick) begin
            if (!dir_down) begin
                next_cnt = at_top ? `TBCNT_ZERO16 : cnt + `TBCNT_ONE16;
            end else begin
                next_cnt = at_bottom ? top_value : cnt - `TBCNT_ONE16;
            end
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= `TBCNT_ZERO16;
        end else begin
            cnt <= next_cnt;
        end
    end
    assign count = cnt;

    // ======================================================================
    // Working and buffer registers
    // ======================================================================
    tbcnt_reg16 u_per (
        .clk(clk),
        .rst_n(rst_n),
        .rst_val(`TBCNT_PER_RST),
        .load(wr_per),
        .load_data(wdata),
        .xfer(do_upd & top_buffer_valid),
        .xfer_data(top_value_buffer),
        .q(top_value)
    );

    genvar g;
    generate
        for (g = 0; g < `TBCNT_NCMP; g = g + 1) begin : g_cmp
            tbcnt_reg16 u_cmp (
                .clk(clk),
                .rst_n(rst_n),
                .rst_val(`TBCNT_ZERO16),
                .load(wr && (addr == `TBCNT_A_CMP0 + g)),
                .load_data(wdata),
                .xfer(do_upd & match_buffer_valid_n[g]),
                .xfer_data(match_value_buffer_n[g]),
                .q(match_value_n[g])
            );
            assign match_values[g*16 +: 16] = match_value_n[g];
        end
    endgenerate

    integer i;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable <= 1'b0;
            prescale_select <= 3'h0;
            dir_down <= 1'b0;
            lock_update <= 1'b0;
            update_at_bottom <= 1'b0;
            count_on_event_input_enable <= 1'b0;
            top_value_buffer <= `TBCNT_ZERO16;
            top_buffer_valid <= 1'b0;
            match_buffer_valid_n <= 3'h0;
            for (i = 0; i < `TBCNT_NCMP; i = i + 1) begin
                match_value_buffer_n[i] <= `TBCNT_ZERO16;
            end
        end else begin
            if (is_wr(addr, `TBCNT_A_CONTROL_REG_A)) begin
                enable <= wdata[`TBCNT_CA_EN];
                prescale_select <= wdata[`TBCNT_CA_PS_HI:`TBCNT_CA_PS_LO];
            end
            if (is_wr(addr, `TBCNT_A_CONTROL_REG_E)) begin
                dir_down <= wdata[`TBCNT_CE_DIR];
                lock_update <= wdata[`TBCNT_CE_LOCK_UPDATE];
                update_at_bottom <= wdata[`TBCNT_CE_UPDBOT];
            end
            if (is_wr(addr, `TBCNT_A_EVENT_CONTROL_REG)) begin
                count_on_event_input_enable <= wdata[`TBCNT_EV_COUNT_ON_EVENT_INPUT_ENABLE];
            end
            // Buffer-valid: a write in the transfer cycle wins and keeps the flag set.
            if (wr_top_value_buffer) begin
                top_value_buffer <= wdata;
                top_buffer_valid <= 1'b1;
            end else if (do_upd) begin
                top_buffer_valid <= 1'b0;
            end else if (is_wr(addr, `TBCNT_A_CONTROL_REG_F)) begin
                top_buffer_valid <= wdata[`TBCNT_CF_TOP_BUFFER_VALID];
            end
            for (i = 0; i < `TBCNT_NCMP; i = i + 1) begin
                if (is_wr(addr, `TBCNT_A_CMPBUF0 + i[4:0])) begin
                    match_value_buffer_n[i] <= wdata;
                    match_buffer_valid_n[i] <= 1'b1;
                end else if (do_upd) begin
                    match_buffer_valid_n[i] <= 1'b0;
                end else if (is_wr(addr, `TBCNT_A_CONTROL_REG_F)) begin
                    match_buffer_valid_n[i] <= wdata[i+1];
                end
            end
        end
    end

    // ======================================================================
    // Event outputs, one tick after the condition
    // ======================================================================
    reg p_top, p_bot, p_max, p_upd;
    reg [2:0] p_match;
    integer j;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p_top <= 1'b0;
            p_bot <= 1'b0;
            p_max <= 1'b0;
            p_upd <= 1'b0;
            p_match <= 3'h0;
            ev_top <= 1'b0;
            ev_bottom <= 1'b0;
            ev_max <= 1'b0;
            ev_match <= 3'h0;
            update_strobe <= 1'b0;
        end else begin
            // Conditions are latched on a tick and emitted on the next tick.
            if (timer_tick) begin
                p_top <= at_top;
                p_bot <= at_bottom;
                p_max <= at_max;
                p_upd <= upd_cond & ~lock_update;
                for (j = 0; j < `TBCNT_NCMP; j = j + 1) begin
                    p_match[j] <= (cnt == match_value_n[j]);
                end
            end
            ev_top <= timer_tick & p_top;
            ev_bottom <= timer_tick & p_bot;
            ev_max <= timer_tick & p_max;
            ev_match <= {3{timer_tick}} & p_match;
            update_strobe <= timer_tick & p_upd;
        end
    end

    // ======================================================================
    // Register read port
    // ======================================================================
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= `TBCNT_ZERO16;
        end else if (rd) begin
            if (addr == `TBCNT_A_CONTROL_REG_A) begin
                rdata <= {12'h000, prescale_select, enable};
            end else if (addr == `TBCNT_A_CONTROL_REG_E) begin
                rdata <= {13'h0000, update_at_bottom, lock_update, dir_down};
            end else if (addr == `TBCNT_A_CONTROL_REG_F) begin
                rdata <= {12'h000, match_buffer_valid_n, top_buffer_valid};
            end else if (addr == `TBCNT_A_EVENT_CONTROL_REG) begin
                rdata <= {15'h0000, count_on_event_input_enable};
            end else if (addr == `TBCNT_A_CNT) begin
                rdata <= cnt;
            end else if (addr == `TBCNT_A_PER) begin
                rdata <= top_value;
            end else if (addr == `TBCNT_A_TOP_VALUE_BUFFER) begin
                rdata <= top_value_buffer;
            end else if (addr >= `TBCNT_A_CMP0 && addr < `TBCNT_A_CMP0 + 5'h03) begin
                rdata <= match_value_n[addr[1:0]];
            end else if (addr >= `TBCNT_A_CMPBUF0 && addr < `TBCNT_A_CMPBUF0 + 5'h03) begin
                rdata <= match_value_buffer_n[addr[1:0]];
            end else begin
                rdata <= `TBCNT_ZERO16;
            end
        end else begin
            rdata <= `TBCNT_ZERO16;
        end
    end
endmodule

// [inc/tbcnt_defs.vh]
// Register map, field layout, reset values and constants of the timer base counter.
`ifndef TBCNT_DEFS_VH
`define TBCNT_DEFS_VH

// ==========================================================================
// Register indices (word offsets of the plain register port)
// ==========================================================================
`define TBCNT_ADDR_W 5
`define TBCNT_A_CONTROL_REG_A 5'h00
`define TBCNT_A_CONTROL_REG_E 5'h01
`define TBCNT_A_CONTROL_REG_F 5'h02
`define TBCNT_A_EVENT_CONTROL_REG 5'h03
`define TBCNT_A_CNT 5'h04
`define TBCNT_A_PER 5'h05
`define TBCNT_A_TOP_VALUE_BUFFER 5'h06
`define TBCNT_A_CMP0 5'h08
`define TBCNT_A_CMPBUF0 5'h0c
`define TBCNT_A_STATUS 5'h10

// ==========================================================================
// Field positions
// ==========================================================================
`define TBCNT_CA_EN 0
`define TBCNT_CA_PS_LO 1
`define TBCNT_CA_PS_HI 3
`define TBCNT_CE_DIR 0
`define TBCNT_CE_LOCK_UPDATE 1
`define TBCNT_CE_UPDBOT 2
`define TBCNT_CF_TOP_BUFFER_VALID 0
`define TBCNT_EV_COUNT_ON_EVENT_INPUT_ENABLE 0

// ==========================================================================
// Reset values and constants
// ==========================================================================
`define TBCNT_PER_RST 16'hffff
`define TBCNT_ZERO16 16'h0000
`define TBCNT_MAX16 16'hffff
`define TBCNT_ONE16 16'h0001
`define TBCNT_NCMP 3
`define TBCNT_PS_W 3
`define TBCNT_PS_CNT_W 10

`endif

// [verilog/tbcnt_reg16.v]
// A 16-bit storage register with a direct load and a buffered transfer.
`timescale 1ns/1ps
module tbcnt_reg16 (
    input wire clk, // Clock.
    input wire rst_n, // Synchronised reset, active low.
    input wire [15:0] rst_val, // Reset value input, not used; q resets to zero.
    input wire load, // Direct software write.
    input wire [15:0] load_data, // Data of the direct write.
    input wire xfer, // Buffered transfer strobe.
    input wire [15:0] xfer_data, // Buffer content to transfer.
    output reg [15:0] q // Stored value.
);
    // A direct write beats a transfer in the same cycle since software asked last.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= `TBCNT_ZERO16;
        end else if (load) begin
            q <= load_data;
        end else if (xfer) begin
            q <= xfer_data;
        end
    end
endmodule

// [tb/tbcnt_top_asserts.sv]
// Port checker of the timer base counter.
`timescale 1ns/1ps
`include "tbcnt_defs.vh"
module tbcnt_asserts (
    input wire clk, // Clock.
    input wire arst_n, // Reset, active low.
    input wire [4:0] addr, // Index.
    input wire [15:0] wdata, // Write data.
    input wire wr, // Write strobe.
    input wire rd, // Read strobe.
    input wire [15:0] rdata, // Read data.
    input wire ev_top, // Top event.
    input wire ev_bottom, // Bottom event.
    input wire update_strobe, // Update event.
    input wire [15:0] count, // Counter.
    input wire [47:0] match_values // Match values.
);
    wire cnt_wr = wr && addr == `TBCNT_A_CNT;
    wire [2:0] wd3 = wdata[2:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_ce_wr;
        wr && addr == `TBCNT_A_CONTROL_REG_E;
    endsequence
    sequence s_ce_rd;
        rd && addr == `TBCNT_A_CONTROL_REG_E;
    endsequence
    a_cnt_write: assert property (cnt_wr |=> count == $past(wdata))
        else $error("counter write not taken");
    a_cnt_read: assert property (rd && addr == `TBCNT_A_CNT |=> rdata == $past(count))
        else $error("counter read wrong");
    // A change without a write is one step, a clear to zero or a reload from zero.
    a_count_step: assert property (!$past(cnt_wr) && count != $past(count) |->
        count == $past(count) + 16'h0001 || count == $past(count) - 16'h0001 ||
        count == 16'h0000 || $past(count) == 16'h0000)
        else $error("counter jumped");
    a_match_write: assert property (wr && addr[4:2] == 3'h2 && addr[1:0] != 2'h3 |=>
        match_values[{$past(addr[1:0]), 4'h0} +: 16] == $past(wdata))
        else $error("match write not direct");
    a_update_cause: assert property (update_strobe |-> ev_top || ev_bottom)
        else $error("update without top or bottom");
    a_unmapped_zero: assert property (rd && addr == 5'h07 |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data without read");
    a_control_reg_e_back: assert property (s_ce_wr ##1 !wr ##1 s_ce_rd |=> rdata[2:0] == $past(wd3, 3))
        else $error("control e readback wrong");
endmodule
bind tbcnt_top tbcnt_asserts tbcnt_asserts_inst (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ev_top(ev_top), .ev_bottom(ev_bottom),
    .update_strobe(update_strobe), .count(count), .match_values(match_values));

// [tb/tb_tbcnt_top.sv]
// Self-checking testbench of the timer base counter.
`timescale 1ns/1ps
`include "tbcnt_defs.vh"
module tb_tbcnt_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic event_in = 1'b0;
    wire [15:0] rdata;
    wire ev_top, ev_bottom, ev_max, update_strobe;
    wire [2:0] ev_match;
    wire [15:0] count;
    wire [47:0] match_values;
    logic [15:0] d, n;
    logic s_top, s_bot, s_max, s_upd;
    logic [2:0] s_mch;
    logic [15:0] dv [8] = '{16'h1, 16'h2, 16'h4, 16'h8, 16'h10, 16'h40, 16'h100, 16'h400};
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    tbcnt_top tbcnt_top_inst (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .event_in(event_in), .ev_top(ev_top),
        .ev_bottom(ev_bottom), .ev_max(ev_max), .ev_match(ev_match),
        .update_strobe(update_strobe), .count(count), .match_values(match_values));
    initial begin
        forever #5 clk = ~clk;
    end
    // Sticky event flags; the ceiling covers the slowest prescaler pass several times.
    always @(posedge clk) begin
        cycles++;
        if (ev_top === 1'b1) s_top = 1'b1;
        if (ev_bottom === 1'b1) s_bot = 1'b1;
        if (ev_max === 1'b1) s_max = 1'b1;
        if (update_strobe === 1'b1) s_upd = 1'b1;
        s_mch = s_mch | ev_match;
        if (cycles == 40000) begin
            num_errors++;
            conclude();
        end
    end
    task ck(input logic [15:0] g, input logic [15:0] e, input string m);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task w(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task r(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task step();
        @(posedge clk);
        #1;
    endtask
    task till(input logic [15:0] v);
        int i;
        for (i = 0; i < 3000 && count !== v; i++) step();
        ck(count, v, "count value not reached");
    endtask
    task t_regs();
        r(`TBCNT_A_PER, d);
        ck(d, 16'h0000, "period reset");
        r(5'h07, d);
        ck(d, 16'h0000, "unmapped read");
        w(`TBCNT_A_CONTROL_REG_E, 16'h0005);
        r(`TBCNT_A_CONTROL_REG_E, d);
        ck(d, 16'h0005, "control e readback");
        $display("t_regs done");
    endtask
    task t_updown();
        w(`TBCNT_A_CONTROL_REG_E, 16'h0000);
        w(`TBCNT_A_PER, 16'h0003);
        w(`TBCNT_A_CONTROL_REG_A, 16'h0001);
        {s_top, s_bot, s_upd} = 3'b000;
        s_mch = 3'b000;
        till(16'h0003);
        step();
        ck(count, 16'h0000, "no wrap at top");
        repeat (8) step();
        ck({s_top, s_bot, s_upd}, 16'h0007, "top bottom update events");
        ck({13'h0000, s_mch}, 16'h0007, "match events");
        w(`TBCNT_A_CONTROL_REG_E, 16'h0001);
        till(16'h0000);
        step();
        ck(count, 16'h0003, "no reload at bottom");
        $display("t_updown done");
    endtask
    task t_prescale();
        int p;
        for (p = 0; p < 8; p++) begin
            w(`TBCNT_A_CONTROL_REG_A, {12'h000, p[2:0], 1'b1});
            d = count;
            for (int i = 0; i < 2100 && count === d; i++) step();
            d = count;
            n = 16'h0000;
            for (int i = 0; i < 2100 && count === d; i++) begin
                step();
                n++;
            end
            ck(n, dv[p], "tick spacing");
        end
        $display("t_prescale done");
    endtask
    task t_stop();
        w(`TBCNT_A_CONTROL_REG_A, 16'h0000);
        d = count;
        repeat (20) step();
        ck(count, d, "count moved while off");
        w(`TBCNT_A_CNT, 16'h1234);
        repeat (5) step();
        ck(count, 16'h1234, "write while off");
        r(`TBCNT_A_CNT, d);
        ck(d, 16'h1234, "counter readback");
        $display("t_stop done");
    endtask
    task t_event();
        w(`TBCNT_A_CONTROL_REG_E, 16'h0000);
        w(`TBCNT_A_PER, 16'hffff);
        w(`TBCNT_A_CNT, 16'h0000);
        w(`TBCNT_A_EVENT_CONTROL_REG, 16'h0001);
        w(`TBCNT_A_CONTROL_REG_A, 16'h0001);
        repeat (10) step();
        ck(count, 16'h0000, "counted without events");
        repeat (5) begin
            @(posedge clk) event_in <= 1'b1;
            @(posedge clk) event_in <= 1'b0;
        end
        repeat (3) step();
        ck(count, 16'h0005, "event count");
        w(`TBCNT_A_EVENT_CONTROL_REG, 16'h0000);
        $display("t_event done");
    endtask
    task t_period();
        w(`TBCNT_A_CNT, 16'hfff0);
        w(`TBCNT_A_PER, 16'h0010);
        s_max = 1'b0;
        till(16'h0000);
        repeat (3) step();
        ck(s_max, 1'b1, "max event");
        till(16'h0010);
        step();
        ck(count, 16'h0000, "new period not used");
        $display("t_period done");
    endtask
    task t_buffer();
        w(`TBCNT_A_CONTROL_REG_A, 16'h0000);
        w(`TBCNT_A_CNT, 16'h0000);
        w(`TBCNT_A_PER, 16'h0007);
        w(`TBCNT_A_TOP_VALUE_BUFFER, 16'h0003);
        w(`TBCNT_A_CMPBUF0, 16'h0abc);
        w(`TBCNT_A_CMP0 + 5'h01, 16'h0055);
        ck(match_values[31:16], 16'h0055, "direct match write");
        r(`TBCNT_A_PER, d);
        ck(d, 16'h0007, "period changed early");
        r(`TBCNT_A_CONTROL_REG_F, d);
        ck(d, 16'h0003, "valid flags not set");
        w(`TBCNT_A_CONTROL_REG_A, 16'h0001);
        repeat (20) step();
        r(`TBCNT_A_PER, d);
        ck(d, 16'h0003, "period not updated");
        ck(match_values[15:0], 16'h0abc, "match not updated");
        r(`TBCNT_A_CONTROL_REG_F, d);
        ck(d, 16'h0000, "valid flags not cleared");
        w(`TBCNT_A_CONTROL_REG_E, 16'h0002);
        w(`TBCNT_A_TOP_VALUE_BUFFER, 16'h0005);
        s_upd = 1'b0;
        repeat (20) step();
        r(`TBCNT_A_PER, d);
        ck(d, 16'h0003, "update while locked");
        ck(s_upd, 1'b0, "update strobe while locked");
        w(`TBCNT_A_EVENT_CONTROL_REG, 16'h0001);
        w(`TBCNT_A_CNT, 16'h0001);
        w(`TBCNT_A_CONTROL_REG_E, 16'h0004);
        @(posedge clk) event_in <= 1'b1;
        @(posedge clk) event_in <= 1'b0;
        r(`TBCNT_A_PER, d);
        ck(d, 16'h0003, "update away from bottom");
        w(`TBCNT_A_CNT, 16'h0000);
        @(posedge clk) event_in <= 1'b1;
        @(posedge clk) event_in <= 1'b0;
        r(`TBCNT_A_PER, d);
        ck(d, 16'h0005, "no update at bottom");
        $display("t_buffer done");
    endtask
    task conclude();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_updown();
        t_prescale();
        t_stop();
        t_event();
        t_period();
        t_buffer();
        conclude();
    end
endmodule
